/* rtl/txs_pa_sequencer.sv */
// power table index sequencer for keying and ramping
`timescale 1ns/100ps

module txs_pa_sequencer #(
	parameter int IDX_W = 3
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// control
	input  wire logic [IDX_W-1:0] pa_level_index,
	input  wire logic             tx_active,
	input  wire logic             ask_mode,
	input  wire logic             tx_symbol,
	input  wire logic             pa_step,
	// table selection
	output logic      [IDX_W-1:0] power_table_index,
	output logic                  pa_settled
);

	typedef struct packed {
		logic [IDX_W-1:0] idx;
	} txs_seq_state_type;

	txs_seq_state_type s_q;
	txs_seq_state_type s_d;
	logic [IDX_W-1:0]  target;

	// ------------------------------------------------------------
	// target entry and stepping
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		// level picks the entry while sending
		target = pa_level_index;
		if (!tx_active)
			target = '0;
		else if (ask_mode && !tx_symbol)
			target = '0;
		else if (ask_mode && tx_symbol)
			target = pa_level_index;
		// one entry per step toward the target
		if (pa_step && s_q.idx < target)
			s_d.idx = s_q.idx + 1'b1;
		else if (pa_step && s_q.idx > target)
			s_d.idx = s_q.idx - 1'b1;
	end

	// state register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign power_table_index = s_q.idx;
	assign pa_settled        = (s_q.idx == target);

endmodule

/* rtl/txs_pkg.sv */
// constants and types for the tx front end and synth calibration registers
package txs_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] OFS_TX_FRONT_END_CONFIG   = 6'h22;
	localparam logic [5:0] OFS_SYNTH_CAL_PUMP        = 6'h23;
	localparam logic [5:0] OFS_SYNTH_CAL_VCO_CURRENT = 6'h24;
	localparam logic [5:0] OFS_SYNTH_CAL_CAPACITOR   = 6'h25;
	localparam logic [5:0] OFS_SYNTH_CAL_CONTROL     = 6'h26;
	localparam logic [5:0] OFS_RC_OSC_TRIM_UPPER     = 6'h27;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int POS_LO_BUF   = 4;
	localparam int POS_PA_LEVEL = 0;
	localparam int POS_CAL_CFG  = 6;
	localparam int POS_PUMP_EN  = 4;
	localparam int POS_PUMP     = 0;
	localparam int POS_VCO_HIGH = 5;
	localparam int POS_VCO_CUR  = 0;
	localparam int POS_CAP      = 0;
	localparam int POS_CAL_CTRL = 0;
	localparam int POS_RC_TRIM  = 0;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [1:0] RST_LO_BUF   = 2'h1;
	localparam logic [2:0] RST_PA_LEVEL = 3'h0;
	localparam logic [1:0] RST_CAL_CFG  = 2'h2;
	localparam logic [1:0] RST_PUMP_EN  = 2'h2;
	localparam logic [3:0] RST_PUMP     = 4'h9;
	localparam logic       RST_VCO_HIGH = 1'b0;
	localparam logic [4:0] RST_VCO_CUR  = 5'h0a;
	localparam logic [5:0] RST_CAP      = 6'h20;
	localparam logic [6:0] RST_CAL_CTRL = 7'h0d;
	localparam logic [6:0] RST_RC_TRIM  = 7'h41;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] lo_buf;
		logic [2:0] pa_level;
		logic [1:0] cal_cfg;
		logic [1:0] pump_en;
		logic [3:0] pump;
		logic       vco_high;
		logic [4:0] vco_cur;
		logic [5:0] cap;
		logic [6:0] cal_ctrl;
		logic [6:0] rc_trim;
	} txs_regs_type;

	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_PUMP,
		CAL_VCO,
		CAL_CAP
	} txs_cal_state_type;

	localparam txs_regs_type RST_REGS = '{
		lo_buf:   RST_LO_BUF,
		pa_level: RST_PA_LEVEL,
		cal_cfg:  RST_CAL_CFG,
		pump_en:  RST_PUMP_EN,
		pump:     RST_PUMP,
		vco_high: RST_VCO_HIGH,
		vco_cur:  RST_VCO_CUR,
		cap:      RST_CAP,
		cal_ctrl: RST_CAL_CTRL,
		rc_trim:  RST_RC_TRIM
	};

endpackage

/* rtl/txs_tx_frontend_synth_cal_regs.sv */
// tx front end and synthesizer calibration register bank
`timescale 1ns/100ps

module txs_tx_frontend_synth_cal_regs #(
	parameter int ADDR_W = 6,
	parameter int DATA_W = 8
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	// register access from the host port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [DATA_W-1:0] reg_wdata,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   reg_rvalid,
	// calibration engine handshake
	input  wire logic              cal_start,
	input  wire logic              cal_stage_done,
	input  wire logic [DATA_W-1:0] cal_result,
	output logic                   cal_busy,
	output logic                   cal_pump_stage,
	output logic                   cal_vco_stage,
	output logic                   cal_cap_stage,
	// synthesizer settings
	output logic      [3:0]        pump_current_code,
	output logic      [4:0]        vco_current_code,
	output logic                   vco_high_core_select,
	output logic      [5:0]        vco_cap_code,
	output logic      [1:0]        cal_config,
	output logic      [6:0]        cal_control,
	// transmit front end
	input  wire logic              tx_active,
	input  wire logic              ask_mode,
	input  wire logic              tx_symbol,
	input  wire logic              pa_step,
	output logic      [2:0]        power_level_table_index,
	output logic                   pa_settled,
	output logic      [1:0]        tx_lo_buffer_current,
	// rc oscillator
	input  wire logic              rc_calibration_enable,
	input  wire logic              rc_calibration_enable_request,
	output logic                   rc_calibration_enable_run,
	output logic      [6:0]        rc_trim_upper
);

	typedef struct packed {
		txs_pkg::txs_regs_type      regs;
		txs_pkg::txs_cal_state_type cal;
		logic [DATA_W-1:0]          rdata;
		logic                       rvalid;
	} txs_bank_state_type;

	txs_bank_state_type s_q;
	txs_bank_state_type s_d;

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	function automatic logic [DATA_W-1:0] read_reg(
		input txs_pkg::txs_regs_type r,
		input logic [ADDR_W-1:0]     a
	);
		logic [DATA_W-1:0] v;
		v = '0;
		// unused positions stay zero
		case (a)
			txs_pkg::OFS_TX_FRONT_END_CONFIG:
			begin
				v[txs_pkg::POS_LO_BUF +: 2]   = r.lo_buf;
				v[txs_pkg::POS_PA_LEVEL +: 3] = r.pa_level;
			end
			txs_pkg::OFS_SYNTH_CAL_PUMP:
			begin
				v[txs_pkg::POS_CAL_CFG +: 2] = r.cal_cfg;
				v[txs_pkg::POS_PUMP_EN +: 2] = r.pump_en;
				v[txs_pkg::POS_PUMP +: 4]    = r.pump;
			end
			txs_pkg::OFS_SYNTH_CAL_VCO_CURRENT:
			begin
				v[txs_pkg::POS_VCO_HIGH]     = r.vco_high;
				v[txs_pkg::POS_VCO_CUR +: 5] = r.vco_cur;
			end
			txs_pkg::OFS_SYNTH_CAL_CAPACITOR:
				v[txs_pkg::POS_CAP +: 6] = r.cap;
			txs_pkg::OFS_SYNTH_CAL_CONTROL:
				v[txs_pkg::POS_CAL_CTRL +: 7] = r.cal_ctrl;
			txs_pkg::OFS_RC_OSC_TRIM_UPPER:
				v[txs_pkg::POS_RC_TRIM +: 7] = r.rc_trim;
			default:
				v = '0; // unmapped reads zero
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;
		// read data registered one cycle after the strobe
		if (reg_rd)
		begin
			s_d.rdata  = read_reg(s_q.regs, reg_addr);
			s_d.rvalid = 1'b1;
		end
		// software writes, only defined bits kept
		if (reg_wr)
		begin
			case (reg_addr)
				txs_pkg::OFS_TX_FRONT_END_CONFIG:
				begin
					s_d.regs.lo_buf   = reg_wdata[txs_pkg::POS_LO_BUF +: 2];
					s_d.regs.pa_level = reg_wdata[txs_pkg::POS_PA_LEVEL +: 3];
				end
				txs_pkg::OFS_SYNTH_CAL_PUMP:
				begin
					// config bits loaded by software before a run
					s_d.regs.cal_cfg = reg_wdata[txs_pkg::POS_CAL_CFG +: 2];
					s_d.regs.pump_en = reg_wdata[txs_pkg::POS_PUMP_EN +: 2];
					s_d.regs.pump    = reg_wdata[txs_pkg::POS_PUMP +: 4];
				end
				txs_pkg::OFS_SYNTH_CAL_VCO_CURRENT:
				begin
					s_d.regs.vco_high = reg_wdata[txs_pkg::POS_VCO_HIGH];
					s_d.regs.vco_cur  = reg_wdata[txs_pkg::POS_VCO_CUR +: 5];
				end
				txs_pkg::OFS_SYNTH_CAL_CAPACITOR:
					s_d.regs.cap = reg_wdata[txs_pkg::POS_CAP +: 6];
				txs_pkg::OFS_SYNTH_CAL_CONTROL:
					s_d.regs.cal_ctrl = reg_wdata[txs_pkg::POS_CAL_CTRL +: 7];
				txs_pkg::OFS_RC_OSC_TRIM_UPPER:
					s_d.regs.rc_trim = reg_wdata[txs_pkg::POS_RC_TRIM +: 7];
				default:
					s_d.regs = s_q.regs;
			endcase
		end
		// calibration sequence; a stage result beats a same-cycle write
		case (s_q.cal)
			txs_pkg::CAL_IDLE:
			begin
				if (cal_start && s_q.regs.pump_en == 2'h0)
					s_d.cal = txs_pkg::CAL_VCO;
				else if (cal_start)
					s_d.cal = txs_pkg::CAL_PUMP;
			end
			txs_pkg::CAL_PUMP:
			begin
				if (cal_stage_done)
				begin
					s_d.regs.pump = cal_result[3:0];
					s_d.cal       = txs_pkg::CAL_VCO;
				end
			end
			txs_pkg::CAL_VCO:
			begin
				if (cal_stage_done)
				begin
					s_d.regs.vco_cur = cal_result[4:0];
					s_d.cal          = txs_pkg::CAL_CAP;
				end
			end
			txs_pkg::CAL_CAP:
			begin
				if (cal_stage_done)
				begin
					s_d.regs.cap = cal_result[5:0];
					s_d.cal      = txs_pkg::CAL_IDLE;
				end
			end
			default:
				s_d.cal = txs_pkg::CAL_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			s_q.regs   <= txs_pkg::RST_REGS;
			s_q.cal    <= txs_pkg::CAL_IDLE;
			s_q.rdata  <= '0;
			s_q.rvalid <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata      = s_q.rdata;
	assign reg_rvalid     = s_q.rvalid;
	assign cal_busy       = (s_q.cal != txs_pkg::CAL_IDLE);
	assign cal_pump_stage = (s_q.cal == txs_pkg::CAL_PUMP);
	assign cal_vco_stage  = (s_q.cal == txs_pkg::CAL_VCO);
	assign cal_cap_stage  = (s_q.cal == txs_pkg::CAL_CAP);

	// stored results drive the synthesizer directly
	assign pump_current_code    = s_q.regs.pump;
	assign vco_current_code     = s_q.regs.vco_cur;
	assign vco_cap_code         = s_q.regs.cap;
	assign vco_high_core_select = s_q.regs.vco_high;
	assign cal_config           = s_q.regs.cal_cfg;
	assign cal_control          = s_q.regs.cal_ctrl;
	assign tx_lo_buffer_current = s_q.regs.lo_buf;
	assign rc_trim_upper        = s_q.regs.rc_trim;
	assign rc_calibration_enable_run = rc_calibration_enable & rc_calibration_enable_request;

	// power table index sequencing
	txs_pa_sequencer #(
		.IDX_W (3)
	) u_pa_seq (
		.clk_sys           (clk_sys),
		.sys_rst           (sys_rst),
		.pa_level_index    (s_q.regs.pa_level),
		.tx_active         (tx_active),
		.ask_mode          (ask_mode),
		.tx_symbol         (tx_symbol),
		.pa_step           (pa_step),
		.power_table_index (power_level_table_index),
		.pa_settled        (pa_settled)
	);

endmodule

/* verif/tb_txs_tx_frontend_synth_cal_regs.sv */
// self-checking bench for the tx front end and synth calibration registers
`timescale 1ns/100ps

module tb_txs_tx_frontend_synth_cal_regs;
	// design signals
	logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00, cal_result = 8'h00, reg_rdata, rd_q;
	logic cal_start = 1'b0, cal_stage_done = 1'b0, tx_active = 1'b0;
	logic ask_mode = 1'b0, tx_symbol = 1'b0, pa_step = 1'b0;
	logic rc_calibration_enable = 1'b0, rc_calibration_enable_request = 1'b0;
	logic reg_rvalid, cal_busy, cal_pump_stage, cal_vco_stage, cal_cap_stage;
	logic vco_high_core_select, pa_settled, rc_calibration_enable_run;
	logic [3:0] pump_current_code;
	logic [4:0] vco_current_code;
	logic [5:0] vco_cap_code;
	logic [1:0] cal_config, tx_lo_buffer_current;
	logic [6:0] cal_control, rc_trim_upper;
	logic [2:0] power_level_table_index;
	int n_fail = 0, n_compared = 0;
	// rows: address, write data, read back
	logic [23:0] rows [8] = '{24'h22ff37, 24'h23ffff, 24'h24ff3f,
		24'h25ff3f, 24'h26ff7f, 24'h27ff7f, 24'h28ff00, 24'h21ff00};
	logic [7:0] rst_exp [6] = '{8'h10, 8'ha9, 8'h0a, 8'h20, 8'h0d, 8'h41};

	txs_tx_frontend_synth_cal_regs u_txs_tx_frontend_synth_cal_regs (
		.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .reg_rvalid, .cal_start, .cal_stage_done, .cal_result,
		.cal_busy, .cal_pump_stage, .cal_vco_stage, .cal_cap_stage,
		.pump_current_code, .vco_current_code, .vco_high_core_select,
		.vco_cap_code, .cal_config, .cal_control, .tx_active, .ask_mode,
		.tx_symbol, .pa_step, .power_level_table_index, .pa_settled,
		.tx_lo_buffer_current, .rc_calibration_enable, .rc_calibration_enable_request,
		.rc_calibration_enable_run, .rc_trim_upper
	);

	// clock
	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end

	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		// idle cycle so the next call never re-raises in this step
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [5:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
		rd_q = reg_rdata;
		@(negedge clk_sys);
	endtask
	task automatic step(input int n);
		repeat (n)
		begin
			pa_step = 1'b1;
			@(negedge clk_sys);
		end
		pa_step = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic done(input logic [7:0] r);
		cal_stage_done = 1'b1;
		cal_result = r;
		@(negedge clk_sys);
		cal_stage_done = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			rd(6'h22 + 6'(i));
			chk("reset value", rd_q, rst_exp[i]);
		end
		chk("index", {5'h0, power_level_table_index}, 8'h00);
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(rows[i][21:16], rows[i][15:8]);
			rd(rows[i][21:16]);
			chk("readback", rd_q, rows[i][7:0]);
		end
		chk("vco core", {7'h0, vco_high_core_select}, 8'h01);
		chk("vco current", {3'h0, vco_current_code}, 8'h1f);
		chk("cal control", {1'h0, cal_control}, 8'h7f);
		chk("rc trim", {1'h0, rc_trim_upper}, 8'h7f);
		wr(6'h24, 8'h0a);
		chk("vco core", {7'h0, vco_high_core_select}, 8'h00);
		$display("register rows done");
		// ramp up, keying, ramp down
		wr(6'h22, 8'h13);
		chk("lo buffer", {6'h0, tx_lo_buffer_current}, 8'h01);
		tx_active = 1'b1;
		tx_symbol = 1'b1;
		step(2);
		chk("settled", {7'h0, pa_settled}, 8'h00);
		step(3);
		chk("ramp up", {5'h0, power_level_table_index}, 8'h03);
		ask_mode = 1'b1;
		step(1);
		chk("ask one", {5'h0, power_level_table_index}, 8'h03);
		tx_symbol = 1'b0;
		step(1);
		chk("ask zero", {5'h0, power_level_table_index}, 8'h02);
		step(3);
		chk("ask zero", {5'h0, power_level_table_index}, 8'h00);
		tx_symbol = 1'b1;
		step(3);
		ask_mode = 1'b0;
		tx_active = 1'b0;
		step(3);
		chk("ramp down", {5'h0, power_level_table_index}, 8'h00);
		chk("settled", {7'h0, pa_settled}, 8'h01);
		$display("pa test done");
		// full calibration, then one with the pump stage off
		wr(6'h23, 8'hbf);
		chk("cal config", {6'h0, cal_config}, 8'h02);
		cal_start = 1'b1;
		@(negedge clk_sys);
		cal_start = 1'b0;
		chk("pump stage", {7'h0, cal_pump_stage}, 8'h01);
		done(8'h05);
		chk("pump code", {4'h0, pump_current_code}, 8'h05);
		done(8'h1b);
		chk("vco code", {3'h0, vco_current_code}, 8'h1b);
		chk("cap stage", {7'h0, cal_cap_stage}, 8'h01);
		done(8'h2c);
		chk("cap code", {2'h0, vco_cap_code}, 8'h2c);
		chk("busy", {7'h0, cal_busy}, 8'h00);
		rd(6'h23);
		chk("pump reg", rd_q, 8'hb5);
		wr(6'h23, 8'h8f);
		cal_start = 1'b1;
		@(negedge clk_sys);
		cal_start = 1'b0;
		chk("vco stage", {7'h0, cal_vco_stage}, 8'h01);
		for (int k = 0; cal_busy === 1'b1; k++)
		begin
			if (k == 4)
			begin
				chk("cal timeout", 8'h00, 8'h01);
				complete_run();
			end
			done(8'h00);
		end
		wr(6'h25, 8'h11);
		chk("restored cap", {2'h0, vco_cap_code}, 8'h11);
		wr(6'h23, 8'h27);
		chk("restored pump", {4'h0, pump_current_code}, 8'h07);
		$display("calibration test done");
		// rc oscillator gating
		rc_calibration_enable = 1'b1;
		rc_calibration_enable_request = 1'b1;
		@(negedge clk_sys);
		chk("rc run", {7'h0, rc_calibration_enable_run}, 8'h01);
		rc_calibration_enable = 1'b0;
		@(negedge clk_sys);
		chk("rc run", {7'h0, rc_calibration_enable_run}, 8'h00);
		$display("rc test done");
		// reset again in mid run, values must come back
		sys_rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'b0;
		rd(6'h23);
		chk("reset pump reg", rd_q, 8'ha9);
		rd(6'h25);
		chk("reset cap reg", rd_q, 8'h20);
		chk("reset index", {5'h0, power_level_table_index}, 8'h00);
		$display("second reset test done");
		complete_run();
	end
endmodule

/* verif/txs_regs_assertions.sv */
// checker for the tx front end and synth calibration register bank
`timescale 1ns/100ps

module txs_regs_checker (
	// clock and reset
	input wire logic	clk_sys,
	input wire logic	sys_rst,
	// register port
	input wire logic [5:0]	reg_addr,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [7:0]	reg_wdata,
	input wire logic [7:0]	reg_rdata,
	input wire logic	reg_rvalid,
	// calibration
	input wire logic	cal_start,
	input wire logic	cal_stage_done,
	input wire logic [7:0]	cal_result,
	input wire logic	cal_busy,
	input wire logic	cal_pump_stage,
	input wire logic	cal_vco_stage,
	input wire logic [3:0]	pump_current_code,
	input wire logic [5:0]	vco_cap_code,
	// pa sequencer and rc oscillator
	input wire logic	tx_active,
	input wire logic	pa_step,
	input wire logic [2:0]	power_level_table_index,
	input wire logic	rc_calibration_enable,
	input wire logic	rc_calibration_enable_request,
	input wire logic	rc_calibration_enable_run
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// shadow of the pump calibration enable field
	logic [1:0] pump_en_q;
	always_ff @(posedge clk_sys)
		if (sys_rst)
			pump_en_q <= txs_pkg::RST_PUMP_EN;
		else if (reg_wr && reg_addr == 6'h23)
			pump_en_q <= reg_wdata[5:4];

	// calibration steps
	sequence cal_go_s;
		cal_start && !cal_busy;
	endsequence
	sequence pump_done_s;
		cal_pump_stage && cal_stage_done;
	endsequence

	unmapped_read_a: assert property (
		reg_rd && (reg_addr < 6'h22 || reg_addr > 6'h27)
		|=> reg_rvalid && reg_rdata == 8'h00)
		else $error("unmapped read returned data");
	rc_run_gate_a: assert property (
		rc_calibration_enable_run == (rc_calibration_enable && rc_calibration_enable_request))
		else $error("rc calibration run not gated by enable");
	ramp_down_a: assert property (
		!tx_active && pa_step && power_level_table_index != 3'h0
		|=> power_level_table_index == $past(power_level_table_index) - 3'h1)
		else $error("index did not step down");
	index_hold_a: assert property (
		!pa_step |=> $stable(power_level_table_index))
		else $error("index moved without a step");
	pump_skip_a: assert property (
		cal_go_s ##0 pump_en_q == 2'h0 |=> cal_vco_stage && !cal_pump_stage)
		else $error("pump stage not skipped");
	pump_first_a: assert property (
		cal_go_s ##0 pump_en_q != 2'h0 |=> cal_pump_stage)
		else $error("pump stage not entered");
	pump_store_a: assert property (
		pump_done_s |=> cal_vco_stage
		&& pump_current_code == 4'($past(cal_result)))
		else $error("pump result not stored");
	cap_write_a: assert property (
		reg_wr && reg_addr == 6'h25 && !cal_busy
		|=> vco_cap_code == 6'($past(reg_wdata)))
		else $error("capacitor write not applied");
endmodule

bind txs_tx_frontend_synth_cal_regs txs_regs_checker u_txs_regs_checker (
	.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .reg_rvalid, .cal_start, .cal_stage_done, .cal_result,
	.cal_busy, .cal_pump_stage, .cal_vco_stage, .pump_current_code,
	.vco_cap_code, .tx_active, .pa_step, .power_level_table_index,
	.rc_calibration_enable, .rc_calibration_enable_request, .rc_calibration_enable_run
);
